// [design/rxsf_status.v]
// Receive status flags for two deserializer channels with a plain register port.
// Assumes bit strobes come from the deserializer synchronous to clk.
//
// Design decision made here: strobed register access.
`include "rxsf_regs.vh"

module rxsf_status (
    input  wire       clk,
    input  wire       resetn,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rdata,
    input  wire       bit_tick,
    input  wire       b_bit_stb,
    input  wire       b_bit_val,
    input  wire       b_bit_ok,
    input  wire       a_load,
    input  wire [7:0] a_data,
    input  wire [7:0] a_valid,
    output wire       irq
);

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    reg  [7:0] ctrl;
    reg  [7:0] eof_bits;
    reg  [7:0] irq_mask;
    reg  [7:0] irq_stat;
    wire       rx_en = ctrl[`RXSF_BIT_RX_EN];

    wire rd_status = rd_stb && (addr == `RXSF_ADDR_STATUS);
    wire rd_data_b = rd_stb && (addr == `RXSF_ADDR_DATA_B);

    // Register map
    //   status     : valid B, flow B, EOF B, full B, valid A, three zero bits
    //   data A     : last channel A byte
    //   valid A    : per-bit validity of that byte
    //   data B     : last channel B byte; reading it empties the holding slot
    //   valid B    : per-bit validity of that byte
    //   control    : bit 0 enables reception; off clears every flag
    //   idle count : bit times without a valid bit that end a frame
    //   irq mask   : enables interrupt status bits onto irq
    //   irq status : sticky events, write one to clear
    // Status and data B are the only registers with read side effects

    // ------------------------------------------------------------------------
    // Channel B deserializer
    // ------------------------------------------------------------------------
    reg  [7:0] b_shift;
    reg  [7:0] b_shift_ok;
    reg  [2:0] b_cnt;
    reg        b_started;
    reg  [7:0] b_idle;
    reg  [7:0] b_data;
    reg  [7:0] b_valid;
    reg        b_has;
    reg  [7:0] a_data_q;
    reg  [7:0] a_valid_q;

    // ------------------------------------------------------------------------
    // Per-bit next value of the shifter
    // ------------------------------------------------------------------------
    // Bit 0 arrives first; each strobe fills the position named by b_cnt
    wire [7:0] next_shift;
    wire [7:0] next_shift_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_shift
            wire hit = (b_cnt == gi);
            assign next_shift[gi]    = hit ? b_bit_val : b_shift[gi];
            assign next_shift_ok[gi] = hit ? b_bit_ok  : b_shift_ok[gi];
        end
    endgenerate

    wire b_byte_done = b_bit_stb && (b_cnt == 3'd7);
    // Idle time counts only bit times with no valid bit
    wire b_eof_evt   = rx_en && b_started && bit_tick && !(b_bit_stb && b_bit_ok)
                       && (b_idle + 8'h01 >= eof_bits);
    wire b_partial   = (b_cnt != 3'd0);
    wire b_load      = rx_en && (b_byte_done || (b_eof_evt && b_partial));
    wire [7:0] b_ld_data  = b_byte_done ? next_shift : b_shift;
    wire [7:0] b_ld_valid = b_byte_done ? next_shift_ok : b_shift_ok;

    always @(posedge clk) begin
        if (!resetn || !rx_en) begin
            b_shift    <= 8'h00;
            b_shift_ok <= 8'h00;
            b_cnt      <= 3'd0;
            b_started  <= 1'b0;
        end else begin
            if (b_bit_stb) begin
                b_shift    <= next_shift;
                b_shift_ok <= next_shift_ok;
                b_cnt      <= b_cnt + 3'd1;
                if (b_bit_ok)
                    b_started <= 1'b1;
            end
            // Stale bits of an earlier byte must not leak into a short one
            if (b_load) begin
                b_shift    <= 8'h00;
                b_shift_ok <= 8'h00;
            end
            if (b_eof_evt) begin
                b_started  <= 1'b0;
                b_cnt      <= 3'd0;
                b_shift_ok <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Channel B idle timer
    // ------------------------------------------------------------------------
    // Restarts on every valid bit; stops once a frame has ended
    always @(posedge clk) begin
        if (!resetn || !rx_en) begin
            b_idle <= 8'h00;
        end else if (b_bit_stb && b_bit_ok) begin
            b_idle <= 8'h00;
        end else if (b_eof_evt) begin
            b_idle <= 8'h00;
        end else if (bit_tick && b_started) begin
            b_idle <= b_idle + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Holding registers and status flags
    // ------------------------------------------------------------------------
    reg        valid_b;
    reg        flow_b;
    reg        eof_b;
    reg        full_b;
    reg        valid_a;

    // Overflow: a load lands on unread data; a read in the same cycle drains it
    wire b_over   = b_load && b_has && !rd_data_b;
    // Underflow: the host reads channel B while nothing is held
    wire b_under  = rd_data_b && !b_has;
    wire flow_set = b_over || b_under;

    // Channel B holding register
    always @(posedge clk) begin
        if (!resetn || !rx_en) begin
            b_data  <= 8'h00;
            b_valid <= 8'h00;
            b_has   <= 1'b0;
            valid_b <= 1'b0;
        end else begin
            if (b_load) begin
                b_data  <= b_ld_data;
                b_valid <= b_ld_valid;
                b_has   <= 1'b1;
                valid_b <= (b_ld_valid == `RXSF_FULL_BYTE);
            end else if (rd_data_b) begin
                b_has   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Channel A holding register
    // ------------------------------------------------------------------------
    // The channel A byte, its per-bit validity and the validity summary are all held here
    always @(posedge clk) begin
        if (!resetn || !rx_en) begin
            a_data_q  <= 8'h00;
            a_valid_q <= 8'h00;
            valid_a   <= 1'b0;
        end else if (a_load) begin
            a_data_q  <= a_data;
            a_valid_q <= a_valid;
            valid_a   <= (a_valid == `RXSF_FULL_BYTE);
        end
    end

    // ------------------------------------------------------------------------
    // Channel B event flags
    // ------------------------------------------------------------------------
    // Set wins over the clear-on-read of the status register
    always @(posedge clk) begin
        if (!resetn || !rx_en) begin
            flow_b <= 1'b0;
            eof_b  <= 1'b0;
            full_b <= 1'b0;
        end else begin
            if (flow_set)
                flow_b <= 1'b1;
            else if (rd_status)
                flow_b <= 1'b0;
            if (b_eof_evt)
                eof_b <= 1'b1;
            else if (rd_status)
                eof_b <= 1'b0;
            if (b_load)
                full_b <= 1'b1;
            else if (rd_status)
                full_b <= 1'b0;
        end
    end

    // Low three bits belong to channel A flags that are not held here
    wire [7:0] status = {valid_b, flow_b, eof_b, full_b, valid_a, 3'b000};

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Valid bits are excluded from the event set; events are one-cycle pulses
    wire [7:0] events = {1'b0, flow_set, b_eof_evt, b_load, 4'h0};
    wire       irq_wr = wr_stb && (addr == `RXSF_ADDR_IRQ_STAT);
    wire [7:0] next_irq_stat;

    // A new event in the clearing cycle survives the write-one-to-clear
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq
            assign next_irq_stat[gi] = events[gi] || (irq_stat[gi] && !(irq_wr && wdata[gi]));
        end
    endgenerate

    // Leaving receive mode drops every pending event
    always @(posedge clk) begin
        if (!resetn || !rx_en)
            irq_stat <= 8'h00;
        else
            irq_stat <= next_irq_stat;
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            ctrl     <= `RXSF_CTRL_RESET;
            eof_bits <= `RXSF_EOF_BITS_RST;
            irq_mask <= `RXSF_MASK_RESET;
        end else begin
            if (wr_stb) begin
                case (addr)
                    `RXSF_ADDR_CTRL:     ctrl     <= wdata;
                    `RXSF_ADDR_EOF_BITS: eof_bits <= wdata;
                    `RXSF_ADDR_IRQ_MASK: irq_mask <= wdata;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    // Cycles without a read return zero so the host sees data only once
    reg  [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                `RXSF_ADDR_STATUS:   next_rdata = rx_en ? status : 8'h00;
                `RXSF_ADDR_DATA_A:   next_rdata = a_data_q;
                `RXSF_ADDR_VALID_A:  next_rdata = a_valid_q;
                `RXSF_ADDR_DATA_B:   next_rdata = b_data;
                `RXSF_ADDR_VALID_B:  next_rdata = b_valid;
                `RXSF_ADDR_CTRL:     next_rdata = ctrl;
                `RXSF_ADDR_EOF_BITS: next_rdata = eof_bits;
                `RXSF_ADDR_IRQ_MASK: next_rdata = irq_mask;
                `RXSF_ADDR_IRQ_STAT: next_rdata = irq_stat;
                default:             next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!resetn)
            rdata <= 8'h00;
        else
            rdata <= next_rdata;
    end

endmodule

// [design/rxsf_regs.vh]
// Register offsets, field positions, reset values and timing counts of the
// receive status flag block. Assumes inclusion by bare name from design files.
`ifndef RXSF_REGS_VH
`define RXSF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RXSF_ADDR_STATUS   8'h08
`define RXSF_ADDR_DATA_A   8'h09
`define RXSF_ADDR_VALID_A  8'h0a
`define RXSF_ADDR_DATA_B   8'h0b
`define RXSF_ADDR_VALID_B  8'h0c
`define RXSF_ADDR_CTRL     8'h10
`define RXSF_ADDR_EOF_BITS 8'h11
`define RXSF_ADDR_IRQ_MASK 8'h12
`define RXSF_ADDR_IRQ_STAT 8'h13

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define RXSF_BIT_VALID_B   7
`define RXSF_BIT_FLOW_B    6
`define RXSF_BIT_EOF_B     5
`define RXSF_BIT_FULL_B    4
`define RXSF_BIT_VALID_A   3

// ----------------------------------------------------------------------------
// Control fields, reset values and the full-byte validity pattern
// ----------------------------------------------------------------------------
`define RXSF_BIT_RX_EN     0
`define RXSF_CTRL_RESET    8'h00
`define RXSF_EOF_BITS_RST  8'h04
`define RXSF_MASK_RESET    8'h00
`define RXSF_FULL_BYTE     8'hff

`endif

// [test/rxsf_status_props.sv]
// Port assertions for the receive status flag block.
// Assumes it is bound to rxsf_status, one clock, synchronous low reset.
`include "rxsf_regs.vh"
module rxsf_status_props (
    input wire       clk,
    input wire       resetn,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr_stb,
    input wire       rd_stb,
    input wire [7:0] rdata,
    input wire       bit_tick,
    input wire       b_bit_stb,
    input wire       a_load,
    input wire [7:0] a_valid,
    input wire       irq
);
timeunit 1ns;
timeprecision 1ps;
reg  rx_en;
reg  va;
wire ev = b_bit_stb | bit_tick;
wire rs = rd_stb && addr == `RXSF_ADDR_STATUS;
wire rb = rd_stb && addr == `RXSF_ADDR_DATA_B;
// ----
// Mirror of receive enable and channel A validity
// ----
always @(posedge clk) begin
    if (!resetn) begin
        rx_en <= 1'b0;
        va    <= 1'b0;
    end else if (wr_stb && addr == `RXSF_ADDR_CTRL) begin
        rx_en <= wdata[0];
        va    <= va & wdata[0];
    end else if (a_load && rx_en) begin
        va <= a_valid == 8'hff;
    end
end
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata not idle");
AST_UNMAPPED: assert property (rd_stb && (addr < 8'h08 || addr > 8'h13) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
AST_LOW_ZERO: assert property (rs |=> rdata[2:0] == 3'h0) else $error("status low bits set");
AST_RX_OFF: assert property (rs && !rx_en |=> rdata == 8'h00) else $error("status while off");
AST_CLEAR: assert property (rs && !ev ##1 !ev && !rb ##1 rs && !ev |=> rdata[6:4] == 3'h0)
    else $error("status read did not clear");
AST_UNDER: assert property (rb && !ev ##1 !ev ##1 rb && !ev && rx_en ##1 !ev && !rs ##1 rs && rx_en |=> rdata[6])
    else $error("empty read not flagged");
AST_VALID_A: assert property (rs && rx_en && !a_load |=> rdata[3] == $past(va))
    else $error("valid A wrong");
AST_IRQ_RISE: assert property ($rose(irq) |-> $past(ev || wr_stb || rd_stb))
    else $error("irq rose without cause");
endmodule
bind rxsf_status rxsf_status_props props_u (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .bit_tick(bit_tick),
    .b_bit_stb(b_bit_stb), .a_load(a_load), .a_valid(a_valid), .irq(irq));

// [test/rxsf_link_src.sv]
// Channel B bit source standing in for the deserializer front end.
// Assumes its tasks are called from one process, right after clk edges.
module rxsf_link_src (
    input  wire clk,
    output reg  stb = 1'b0,
    output reg  val = 1'b0,
    output reg  ok = 1'b0,
    output reg  tick = 1'b0
);
timeunit 1ns;
timeprecision 1ps;
task send(input logic [7:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
        @(posedge clk);
        stb <= 1'b1;
        val <= d[i];
        ok  <= m[i];
    end
    @(posedge clk);
    stb <= 1'b0;
    val <= ~val;  // Idle line must not keep the last bit
    ok  <= 1'b0;
endtask
task ticks(input int n);
    repeat (n) begin
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    end
endtask
endmodule

// [test/rxsf_status_test.sv]
// Register-level bench for the receive status flag block.
// Assumes rxsf_link_src drives channel B and the bound checker.
module rxsf_status_test;
timeunit 1ns;
timeprecision 1ps;
logic       clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, a_load = 1'b0;
logic [7:0] addr = 8'h00, wdata = 8'h00, a_data = 8'h00, a_valid = 8'h00, v;
wire  [7:0] rdata;
wire        bit_tick, b_bit_stb, b_bit_val, b_bit_ok, irq;
int         bad_count = 0, n_compared = 0;
always #12.5 clk = ~clk;
rxsf_status dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .bit_tick(bit_tick), .b_bit_stb(b_bit_stb),
    .b_bit_val(b_bit_val), .b_bit_ok(b_bit_ok), .a_load(a_load), .a_data(a_data),
    .a_valid(a_valid), .irq(irq));
rxsf_link_src src_u (.clk(clk), .stb(b_bit_stb), .val(b_bit_val), .ok(b_bit_ok),
    .tick(bit_tick));
// ----
// Bus tasks and comparisons
// ----
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
endtask
task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_stb <= 1'b1; addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
endtask
task rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    n_compared++;
    if (v !== e) begin
        bad_count++;
        $display("mismatch reg %h expected %h seen %h", a, e, v);
    end
endtask
task chk_irq(input logic e);
    #1 n_compared++;
    if (irq !== e) begin
        bad_count++;
        $display("mismatch irq expected %b seen %b", e, irq);
    end
endtask
task stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test;
end
initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rdc(8'h11, 8'h04);
    rdc(8'h20, 8'h00);
    wr(8'h08, 8'hff);
    rdc(8'h08, 8'h00);
    wr(8'h10, 8'h01);
    src_u.send(8'ha5, 8'hff, 8);
    rdc(8'h08, 8'h90);
    chk_irq(1'b0);
    wr(8'h12, 8'hff);
    chk_irq(1'b1);
    rdc(8'h0b, 8'ha5);
    rdc(8'h08, 8'h80);
    wr(8'h13, 8'hff);
    chk_irq(1'b0);
    src_u.send(8'h3c, 8'hef, 8);
    rdc(8'h08, 8'h10);
    src_u.send(8'hff, 8'hff, 8);
    rdc(8'h08, 8'hd0);
    rd(8'h0b, v);
    rd(8'h0b, v);
    rdc(8'h08, 8'hc0);
    rdc(8'h08, 8'h80);
    wr(8'h13, 8'hff);
    src_u.send(8'h07, 8'h07, 3);
    src_u.ticks(3);
    rdc(8'h08, 8'h80);
    src_u.ticks(1);
    rdc(8'h08, 8'h30);
    chk_irq(1'b1);
    rdc(8'h0b, 8'h07);
    rdc(8'h0c, 8'h07);
    wr(8'h13, 8'hff);
    for (int i = 1; i >= 0; i--) begin
        @(posedge clk);
        a_load <= 1'b1; a_data <= 8'h5a; a_valid <= 8'hff >> i;
        @(posedge clk);
        a_load <= 1'b0;
        rdc(8'h08, i ? 8'h00 : 8'h08);
        chk_irq(1'b0);
    end
    wr(8'h10, 8'h00);
    rdc(8'h08, 8'h00);
    stop_test;
end
endmodule
